// ===== rtl/rab_unit.sv
// rotate and bank select unit with its avalon-mm register slave
// Functional notes
// - rotate left: shift up, old bit 7 into bit 0 and carry.
// - rotate left through carry: shift up, old carry into bit 0, bit 7 to carry.
// - rotate right: shift down, old bit 0 into bit 7 and carry.
// - rotate right through carry: shift down, old carry into bit 7, bit 0 to carry.
// - left rotations: carry equals the bit shifted out of bit 7.
// - right rotations: carry equals the bit shifted out of bit 0.
// - overflow set when result bit 7 differs from operand bit 7.
// - zero from result, sign is result bit 7, decimal and half-carry kept.
// - rotate right: opcodes e0 direct, e1 indirect, four cycles.
// - select bank zero: opcode 4f, four cycles, clears bank bit only.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`include "rab_map.svh"
`default_nettype none

module rab_unit
    import rab_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // core side status
    output logic busy_out,
    output logic [7:0] flags_out
);
    // ======================================================================
    // bus handshake
    logic wait_r;
    logic [31:0] rdata_r;
    logic wr_take;
    logic [31:0] rdata_nxt;

    // every access takes exactly two cycles: waitrequest drops for one cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_r <= 1'b1;
        end else if ((avs_read_in || avs_write_in) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    assign wr_take = avs_write_in && !wait_r;
    assign avs_waitrequest_out = wait_r;
    assign avs_readdata_out = rdata_r;

    // ======================================================================
    // state
    rab_state_t state_r;
    logic [2:0] cnt_r;
    logic [7:0] opc_r;
    logic [7:0] arg_r;
    logic [7:0] flags_r;
    logic busy_r;
    logic badop_r;
    logic done_r;
    logic [7:0] tgt_r;
    logic [7:0] rf_r [`RAB_FILE_DEPTH];

    assign busy_out = busy_r;
    assign flags_out = flags_r;

    // ======================================================================
    // decode
    logic dec_valid;
    logic dec_ind;
    logic dec_bank0;
    rab_rot_t dec_kind;

    // unknown codes still take four cycles but write neither the file nor the flags
    always_comb begin
        dec_valid = 1'b1;
        dec_ind = opc_r[0];
        dec_bank0 = 1'b0;
        dec_kind = ROT_LEFT;
        case (opc_r)
            `RAB_OPC_LEFT_D, `RAB_OPC_LEFT_I: dec_kind = ROT_LEFT;
            `RAB_OPC_LEFT_CY_D, `RAB_OPC_LEFT_CY_I: dec_kind = ROT_LEFT_CARRY;
            `RAB_OPC_RIGHT_D, `RAB_OPC_RIGHT_I: dec_kind = ROT_RIGHT;
            `RAB_OPC_RIGHT_CY_D, `RAB_OPC_RIGHT_CY_I: dec_kind = ROT_RIGHT_CARRY;
            `RAB_OPC_BANK0: begin
                dec_bank0 = 1'b1;
                dec_ind = 1'b0;
            end
            default: begin
                dec_valid = 1'b0;
                dec_ind = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // execute strobes: write back in busy cycle two, finish in cycle four
    logic exec_wb;
    logic exec_last;

    assign exec_wb = (state_r == ST_EXEC) && dec_valid;
    assign exec_last = (state_r == ST_HOLD) && (cnt_r == `RAB_EXEC_CYCLES);

    // ======================================================================
    // rotator
    // operand read straight from the target register, no extra latch
    logic [7:0] rot_res;
    logic rot_c;
    logic rot_z;
    logic rot_s;
    logic rot_v;

    rab_rotator u_rot (
        .kind_in(dec_kind),
        .operand_in(rf_r[tgt_r[`RAB_FILE_AW-1:0]]),
        .carry_in(flags_r[`RAB_FLAG_C]),
        .result_out(rot_res),
        .carry_out(rot_c),
        .zero_out(rot_z),
        .sign_out(rot_s),
        .overflow_out(rot_v)
    );

    // ======================================================================
    // control register and start
    logic go;
    logic in_file;
    logic [`RAB_FILE_AW-1:0] file_idx;

    assign go = wr_take && (avs_address_in == `RAB_OFS_CTRL)
        && avs_writedata_in[`RAB_CTRL_GO_BIT] && !busy_r;
    // only aligned words inside the file window reach a register
    assign in_file = (avs_address_in >= `RAB_OFS_FILE_BASE)
        && (avs_address_in < (`RAB_OFS_FILE_BASE + 8'(4 * `RAB_FILE_DEPTH)))
        && (avs_address_in[1:0] == 2'h0);
    assign file_idx = avs_address_in[`RAB_FILE_AW+1:2];

    // opcode and operand byte may be rewritten only while idle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            opc_r <= 8'h00;
            arg_r <= 8'h00;
        end else if (wr_take && (avs_address_in == `RAB_OFS_CTRL) && !busy_r) begin
            opc_r <= avs_writedata_in[`RAB_CTRL_OPC_LSB +: 8];
            arg_r <= avs_writedata_in[`RAB_CTRL_ARG_LSB +: 8];
        end
    end

    // ======================================================================
    // busy: raised by an accepted go, dropped as the last cycle ends
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_r <= 1'b0;
        end else if (go) begin
            busy_r <= 1'b1;
        end else if (exec_last) begin
            busy_r <= 1'b0;
        end
    end

    // ======================================================================
    // execution sequencer: four cycles from go to idle
    // cnt_r numbers the busy cycles, one to four
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (go) begin
                        state_r <= ST_ADDR;
                        cnt_r <= 3'h1;
                    end
                end
                ST_ADDR: begin
                    state_r <= ST_EXEC;
                    cnt_r <= cnt_r + 3'h1;
                end
                ST_EXEC: begin
                    state_r <= ST_HOLD;
                    cnt_r <= cnt_r + 3'h1;
                end
                ST_HOLD: begin
                    if (exec_last) begin
                        state_r <= ST_IDLE;
                        cnt_r <= 3'h0;
                    end else begin
                        cnt_r <= cnt_r + 3'h1;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // target address: operand itself or the register it points at
    // pointer read one cycle ahead of the rotator that needs the target
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tgt_r <= 8'h00;
        end else if (state_r == ST_ADDR) begin
            if (dec_ind) begin
                tgt_r <= rf_r[arg_r[`RAB_FILE_AW-1:0]];
            end else begin
                tgt_r <= arg_r;
            end
        end
    end

    // ======================================================================
    // register file: only the target is written, pointer untouched
    // bus writes during a run are acked and dropped, so no port contention
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < `RAB_FILE_DEPTH; i++) begin
                rf_r[i] <= 8'h00;
            end
        end else if (exec_wb && !dec_bank0) begin
            rf_r[tgt_r[`RAB_FILE_AW-1:0]] <= rot_res;
        end else if (wr_take && in_file && !busy_r) begin
            rf_r[file_idx] <= avs_writedata_in[7:0];
        end
    end

    // ======================================================================
    // flags
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_r <= `RAB_FLAGS_RESET;
        end else if (exec_wb) begin
            if (dec_bank0) begin
                flags_r[`RAB_FLAG_BANK] <= 1'b0;
            end else begin
                // decimal-adjust and half-carry hold their value
                flags_r[`RAB_FLAG_C] <= rot_c;
                flags_r[`RAB_FLAG_Z] <= rot_z;
                flags_r[`RAB_FLAG_S] <= rot_s;
                flags_r[`RAB_FLAG_V] <= rot_v;
            end
        end else if (wr_take && (avs_address_in == `RAB_OFS_FLAGS) && !busy_r) begin
            flags_r <= avs_writedata_in[7:0];
        end
    end

    // ======================================================================
    // sticky status, cleared by the next go; go cannot meet a set while busy
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            badop_r <= 1'b0;
        end else if (state_r == ST_EXEC && !dec_valid) begin
            badop_r <= 1'b1;
        end else if (go) begin
            badop_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_r <= 1'b0;
        end else if (exec_last) begin
            done_r <= 1'b1;
        end else if (go) begin
            done_r <= 1'b0;
        end
    end

    // ======================================================================
    // read data, captured as waitrequest drops
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (avs_address_in == `RAB_OFS_CTRL) begin
            rdata_nxt[`RAB_CTRL_OPC_LSB +: 8] = opc_r;
            rdata_nxt[`RAB_CTRL_ARG_LSB +: 8] = arg_r;
        end else if (avs_address_in == `RAB_OFS_STATUS) begin
            rdata_nxt[`RAB_STAT_BUSY_BIT] = busy_r;
            rdata_nxt[`RAB_STAT_BADOP_BIT] = badop_r;
            rdata_nxt[`RAB_STAT_DONE_BIT] = done_r;
        end else if (avs_address_in == `RAB_OFS_FLAGS) begin
            rdata_nxt[7:0] = flags_r;
        end else if (in_file) begin
            rdata_nxt[7:0] = rf_r[file_idx];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_in && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end
endmodule : rab_unit

`default_nettype wire

// ===== rtl/rab_map.svh
// register offsets, field positions, reset values and timing counts of the rotate unit
`ifndef RAB_MAP_SVH
`define RAB_MAP_SVH

// ==========================================================================
// register byte offsets
`define RAB_OFS_CTRL 8'h00
`define RAB_OFS_STATUS 8'h04
`define RAB_OFS_FLAGS 8'h08
`define RAB_OFS_FILE_BASE 8'h40
`define RAB_FILE_DEPTH 16
`define RAB_FILE_AW 4

// ==========================================================================
// control register fields
`define RAB_CTRL_GO_BIT 0
`define RAB_CTRL_OPC_LSB 8
`define RAB_CTRL_ARG_LSB 16

// ==========================================================================
// status register fields
`define RAB_STAT_BUSY_BIT 0
`define RAB_STAT_BADOP_BIT 1
`define RAB_STAT_DONE_BIT 2

// ==========================================================================
// flag register fields
`define RAB_FLAG_C 7
`define RAB_FLAG_Z 6
`define RAB_FLAG_S 5
`define RAB_FLAG_V 4
`define RAB_FLAG_D 3
`define RAB_FLAG_H 2
`define RAB_FLAG_BANK 0
`define RAB_FLAGS_RESET 8'h00

// ==========================================================================
// opcodes
`define RAB_OPC_LEFT_D 8'h90
`define RAB_OPC_LEFT_I 8'h91
`define RAB_OPC_LEFT_CY_D 8'h10
`define RAB_OPC_LEFT_CY_I 8'h11
`define RAB_OPC_RIGHT_D 8'he0
`define RAB_OPC_RIGHT_I 8'he1
`define RAB_OPC_RIGHT_CY_D 8'hc0
`define RAB_OPC_RIGHT_CY_I 8'hc1
`define RAB_OPC_BANK0 8'h4f

// ==========================================================================
// timing: every instruction here takes four core cycles
`define RAB_EXEC_CYCLES 3'h4

`endif

// ===== rtl/rab_pkg.sv
// types shared by the rotate unit and its rotator
`default_nettype none

package rab_pkg;
    typedef enum logic [1:0] {
        ROT_LEFT,
        ROT_LEFT_CARRY,
        ROT_RIGHT,
        ROT_RIGHT_CARRY
    } rab_rot_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_EXEC,
        ST_HOLD
    } rab_state_t;
endpackage : rab_pkg

`default_nettype wire

// ===== rtl/rab_rotator.sv
// combinational one-bit rotator with flag results
`default_nettype none

module rab_rotator
    import rab_pkg::*;
(
    // operation
    input wire rab_rot_t kind_in,
    input wire logic [7:0] operand_in,
    input wire logic carry_in,
    // results
    output logic [7:0] result_out,
    output logic carry_out,
    output logic zero_out,
    output logic sign_out,
    output logic overflow_out
);
    always_comb begin
        unique case (kind_in)
            ROT_LEFT: begin
                result_out = {operand_in[6:0], operand_in[7]};
                carry_out = operand_in[7];
            end
            ROT_LEFT_CARRY: begin
                result_out = {operand_in[6:0], carry_in};
                carry_out = operand_in[7];
            end
            ROT_RIGHT: begin
                result_out = {operand_in[0], operand_in[7:1]};
                carry_out = operand_in[0];
            end
            ROT_RIGHT_CARRY: begin
                result_out = {carry_in, operand_in[7:1]};
                carry_out = operand_in[0];
            end
        endcase
        zero_out = (result_out == 8'h00);
        sign_out = result_out[7];
        overflow_out = result_out[7] ^ operand_in[7];
    end
endmodule : rab_rotator

`default_nettype wire

// ===== tb/rab_unit_checker.sv
// concurrent checks on the ports of the rotate unit
`default_nettype none

module rab_unit_checker (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // bus and core status
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic busy_out,
    input wire logic [7:0] flags_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic wr_done;
    assign wr_done = avs_write_in && !avs_waitrequest_out;
    // ==========
    // sequences
    sequence s_go;
        wr_done && avs_address_in == 8'h00 && avs_writedata_in[0] && !busy_out;
    endsequence
    sequence s_run;
        busy_out [*4] ##1 !busy_out;
    endsequence
    sequence s_wb;
        $stable(flags_out) ##1 1'b1 ##1 $stable(flags_out) [*2];
    endsequence
    // ==========
    // assertions
    a_go_busy_four: assert property (s_go |=> s_run)
        else $error("go did not give four busy cycles");
    a_flags_one_write: assert property ($rose(busy_out) |=> s_wb)
        else $error("flags moved outside the write back cycle");
    a_dh_kept: assert property (busy_out |=> $stable(flags_out[3:2]))
        else $error("decimal or half carry flag changed");
    a_flags_idle: assert property (!busy_out && !wr_done |=> $stable(flags_out))
        else $error("flags changed while idle");
    a_bank_never_set: assert property ($rose(flags_out[0]) |->
        $past(wr_done && avs_address_in == 8'h08 && avs_writedata_in[0]))
        else $error("bank bit set without a flag write");
    a_bank_only_clear: assert property ($fell(flags_out[0]) && busy_out |->
        $stable(flags_out[7:1]))
        else $error("bank select touched other flags");
    a_zero_not_sign: assert property (busy_out && $changed(flags_out[7:4]) &&
        flags_out[6] |-> !flags_out[5])
        else $error("zero and sign both set");
    a_wait_one_low: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    a_wait_answer: assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("no answer one cycle after request");
endmodule : rab_unit_checker

bind rab_unit rab_unit_checker u_rab_unit_checker (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .busy_out(busy_out),
    .flags_out(flags_out)
);

`default_nettype wire

// ===== tb/rab_unit_tb.sv
// self-checking testbench of the rotate and bank select unit
`default_nettype none

module rab_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] opc;
        logic [7:0] val;
        logic cin;
        logic [7:0] res;
        logic [3:0] czsv;
    } rab_row_t;
    localparam int NROWS = 14;
    localparam rab_row_t ROWS [NROWS] = '{
        '{8'h90, 8'haa, 1'b0, 8'h55, 4'b1001}, '{8'h91, 8'h17, 1'b0, 8'h2e, 4'b0000},
        '{8'h90, 8'h00, 1'b1, 8'h00, 4'b0100}, '{8'h10, 8'haa, 1'b0, 8'h54, 4'b1001},
        '{8'h11, 8'h17, 1'b0, 8'h2e, 4'b0000}, '{8'h10, 8'h00, 1'b1, 8'h01, 4'b0000},
        '{8'h10, 8'h80, 1'b0, 8'h00, 4'b1101}, '{8'he0, 8'h31, 1'b0, 8'h98, 4'b1011},
        '{8'he1, 8'h17, 1'b0, 8'h8b, 4'b1011}, '{8'hc0, 8'h55, 1'b0, 8'h2a, 4'b1000},
        '{8'hc1, 8'h17, 1'b1, 8'h8b, 4'b1011}, '{8'hc0, 8'h01, 1'b0, 8'h00, 4'b1100},
        '{8'he0, 8'hfe, 1'b1, 8'h7f, 4'b0001}, '{8'hc0, 8'hfe, 1'b1, 8'hff, 4'b0010}};
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic busy_out;
    logic [7:0] flags_out;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    always #50 ref_clk_in = ~ref_clk_in;

    rab_unit u_rab_unit (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .busy_out(busy_out),
        .flags_out(flags_out)
    );

    // ==========
    // tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk

    // request held until waitrequest is sampled low; a spare edge before the next one
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic go_op(input logic [7:0] opc, input logic [7:0] arg);
        wr(8'h00, {8'h00, arg, opc, 8'h01});
    endtask : go_op

    task automatic wait_idle(input logic bad);
        logic [31:0] s;
        chk("busy", 32'h1, {31'h0, busy_out});
        do xfer(1'b0, 8'h04, 32'h0, s); while (s[0] !== 1'b0);
        chk("status", {29'h0, 1'b1, bad, 1'b0}, s);
    endtask : wait_idle

    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    // ==========
    // main sequence
    initial begin
        logic [31:0] q;
        rab_row_t r;
        repeat (10) @(posedge ref_clk_in);
        chk("reset flags", 32'h0, {24'h0, flags_out});
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        for (int i = 0; i < NROWS; i++) begin
            r = ROWS[i];
            wr(8'h4c, {24'h0, r.val});
            wr(8'h54, 32'h03);
            wr(8'h08, {24'h0, r.cin, 3'b000, ~r.opc[0], r.opc[0], 2'b01});
            go_op(r.opc, r.opc[0] ? 8'h05 : 8'h03);
            wait_idle(1'b0);
            xfer(1'b0, 8'h4c, 32'h0, q);
            chk("result", {24'h0, r.res}, q);
            chk("flags", {24'h0, r.czsv, ~r.opc[0], r.opc[0], 2'b01}, {24'h0, flags_out});
            xfer(1'b0, 8'h54, 32'h0, q);
            chk("pointer", 32'h03, q);
            $display("row %0d done", i);
        end
        // bank select, with a second go during busy that must be ignored
        wr(8'h4c, 32'h81);
        wr(8'h08, 32'hff);
        go_op(8'h4f, 8'h00);
        go_op(8'h90, 8'h03);
        wait_idle(1'b0);
        chk("bank flags", 32'hfe, {24'h0, flags_out});
        xfer(1'b0, 8'h4c, 32'h0, q);
        chk("ignored go", 32'h81, q);
        $display("bank select done");
        // unknown opcode, with a flag write during busy that must be ignored
        go_op(8'h12, 8'h03);
        wr(8'h08, 32'h00);
        wait_idle(1'b1);
        chk("bad op flags", 32'hfe, {24'h0, flags_out});
        xfer(1'b0, 8'h20, 32'h0, q);
        chk("unmapped", 32'h0, q);
        xfer(1'b0, 8'h00, 32'h0, q);
        chk("control", 32'h0003_1200, q);
        $display("refusals done");
        // reset while idle, after the last run has finished
        rst_in <= 1'b1;
        @(posedge ref_clk_in);
        chk("reset flags", 32'h0, {24'h0, flags_out});
        chk("reset wait", 32'h1, {31'h0, avs_waitrequest_out});
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        xfer(1'b0, 8'h4c, 32'h0, q);
        chk("reset file", 32'h0, q);
        $display("reset done");
        test_done();
    end
endmodule : rab_unit_tb

`default_nettype wire
